// [design/atx_framer.sv]
`timescale 1ns/10ps
`include "atx_cfg.svh"
module atx_framer #(
  parameter int EXTRA_LAT = `ATX_EXTRA_LAT_DEF
) (
  input wire logic mclk,
  input wire logic rst_n,
  input wire logic link_enable,
  input wire logic [2:0] line_rate,
  output logic [`ATX_SEQ_W-1:0] aux_tx_seq,
  output logic [`ATX_LANES-1:0] aux_tx_ctrl,
  output logic aux_tx_bf_pulse,
  output logic aux_tx_hf_pulse,
  output logic [`ATX_BF_W-1:0] aux_tx_bf_num,
  output logic [`ATX_HF_W-1:0] aux_tx_hf_num,
  input wire logic [`ATX_DATA_W-1:0] aux_tx_data,
  input wire logic [`ATX_DATA_W-1:0] aux_tx_mask,
  output logic aux_tx_err,
  output logic direct_tx_ready,
  input wire logic [`ATX_DATA_W-1:0] direct_tx_data,
  input wire logic [`ATX_DATA_W-1:0] ctrl_word_src,
  output logic [`ATX_DATA_W-1:0] tx_word,
  output logic tx_word_valid,
  output logic [`ATX_SEQ_W-1:0] tx_word_seq,
  input wire logic layer1_status_bit_port_los_in,
  input wire logic layer1_status_bit_port_lof_in,
  input wire logic layer1_status_bit_port_rai_in,
  output logic layer1_status_bit_port_los,
  output logic layer1_status_bit_port_lof,
  output logic layer1_status_bit_port_rai
);
  localparam int LAT = 1 + EXTRA_LAT;
  localparam int LAT1 = LAT + 1;

  // ****************************************
  // Frame sync machine and counters
  // ****************************************
  atx_pkg::atx_state_t st_q, st_d;
  logic [`ATX_SEQ_W-1:0] seq_q, seq_d;
  logic [`ATX_BF_W-1:0] bf_q, bf_d;
  logic [`ATX_HF_W-1:0] hf_q, hf_d;
  logic [5:0] cw_bytes;
  logic [5:0] seq_last;

  // Control word length drives both the count period and the slot flags
  always_comb begin
    case (atx_pkg::atx_rate_t'(line_rate))
      atx_pkg::ATX_RATE_0G6: cw_bytes = `ATX_CW_0G6;
      atx_pkg::ATX_RATE_1G2: cw_bytes = `ATX_CW_1G2;
      atx_pkg::ATX_RATE_2G4: cw_bytes = `ATX_CW_2G4;
      atx_pkg::ATX_RATE_3G0: cw_bytes = `ATX_CW_3G0;
      atx_pkg::ATX_RATE_4G9: cw_bytes = `ATX_CW_4G9;
      atx_pkg::ATX_RATE_6G1: cw_bytes = `ATX_CW_6G1;
      atx_pkg::ATX_RATE_9G8: cw_bytes = `ATX_CW_9G8;
      default: cw_bytes = `ATX_CW_0G6;
    endcase
  end

  // Sixteen words per basic frame, four bytes per bus word: 4*W counts
  assign seq_last = 6'({cw_bytes, 2'h0} - 8'h01);

  always_comb begin
    st_d = st_q;
    seq_d = seq_q;
    bf_d = bf_q;
    hf_d = hf_q;
    case (st_q)
      atx_pkg::ATX_ST_IDLE: begin
        seq_d = '0;
        bf_d = '0;
        hf_d = '0;
        if (link_enable) begin
          st_d = atx_pkg::ATX_ST_RUN;
        end
      end
      atx_pkg::ATX_ST_RUN: begin
        if (!link_enable) begin
          st_d = atx_pkg::ATX_ST_IDLE;
        end else if (seq_q >= seq_last) begin
          seq_d = '0;
          if (bf_q == `ATX_BF_LAST) begin
            bf_d = '0;
            hf_d = (hf_q == `ATX_HF_LAST) ? '0 : hf_q + 8'h01;
          end else begin
            bf_d = bf_q + 8'h01;
          end
        end else begin
          seq_d = seq_q + 6'h01;
        end
      end
      default: st_d = atx_pkg::ATX_ST_IDLE;
    endcase
  end

  always_ff @(posedge mclk or negedge rst_n) begin
    if (!rst_n) begin
      st_q <= atx_pkg::ATX_ST_IDLE;
      seq_q <= '0;
      bf_q <= '0;
      hf_q <= '0;
    end else begin
      st_q <= st_d;
      seq_q <= seq_d;
      bf_q <= bf_d;
      hf_q <= hf_d;
    end
  end

  logic run;
  logic kchar_now;
  assign run = (st_q == atx_pkg::ATX_ST_RUN);
  assign aux_tx_seq = seq_q;
  assign aux_tx_bf_num = bf_q;
  assign aux_tx_hf_num = hf_q;
  assign aux_tx_bf_pulse = run && (seq_q == '0);
  assign aux_tx_hf_pulse = run && (seq_q == '0) && (bf_q == '0);
  // Comma or start character sits in the first byte when Z=X=0
  assign kchar_now = aux_tx_hf_pulse && (hf_q == '0);

  // ****************************************
  // Control slot flags per byte lane
  // ****************************************
  genvar gl;
  generate
    for (gl = 0; gl < `ATX_LANES; gl++) begin : g_lane
      logic [7:0] byte_idx;
      // Lane 3 is [31:24], the earliest byte of the group
      assign byte_idx = {seq_q, 2'h0} + 8'(3 - gl);
      assign aux_tx_ctrl[gl] = run && (byte_idx < {2'h0, cw_bytes});
    end
  endgenerate

  // Direct port is offered any count that still has payload bytes
  assign direct_tx_ready = run && (aux_tx_ctrl != 4'hF);

  // ****************************************
  // Write latency pipe
  // ****************************************
  atx_pkg::atx_stage_t pipe_q [LAT];
  atx_pkg::atx_stage_t pipe_d [LAT];
  atx_pkg::atx_stage_t take;

  always_comb begin
    pipe_d[0] = '{vld: run, seq: seq_q, ctrl: aux_tx_ctrl, kchar: kchar_now,
                  dready: direct_tx_ready};
    for (int i = 1; i < LAT; i++) begin
      pipe_d[i] = pipe_q[i-1];
    end
  end

  always_ff @(posedge mclk or negedge rst_n) begin
    if (!rst_n) begin
      for (int i = 0; i < LAT; i++) begin
        pipe_q[i] <= '0;
      end
    end else begin
      for (int i = 0; i < LAT; i++) begin
        pipe_q[i] <= pipe_d[i];
      end
    end
  end

  // Fixed at build time; data is never realigned to fit the user
  assign take = pipe_q[LAT-1];

  // ****************************************
  // Word assembly and fault flag
  // ****************************************
  logic [`ATX_DATA_W-1:0] word_q, word_d, base;
  logic vld_q, vld_d, err_q, err_d;
  logic [`ATX_SEQ_W-1:0] wseq_q, wseq_d;
  logic [2:0] l1_q, l1_d;

  always_comb begin
    for (int l = 0; l < `ATX_LANES; l++) begin
      if (take.ctrl[l]) begin
        base[l*8 +: 8] = ctrl_word_src[l*8 +: 8];
      end else begin
        base[l*8 +: 8] = take.dready ? direct_tx_data[l*8 +: 8] : 8'h00;
      end
    end
    if (take.kchar) begin
      base[31:24] = `ATX_KCHAR;
    end
    // Aux bits land untouched over every other source
    word_d = (aux_tx_data & aux_tx_mask) | (base & ~aux_tx_mask);
    vld_d = take.vld;
    wseq_d = take.seq;
    err_d = take.vld && take.kchar && (aux_tx_mask[31:24] != 8'h00);
    l1_d = {layer1_status_bit_port_rai_in, layer1_status_bit_port_lof_in,
            layer1_status_bit_port_los_in};
  end

  always_ff @(posedge mclk or negedge rst_n) begin
    if (!rst_n) begin
      word_q <= '0;
      vld_q <= 1'b0;
      wseq_q <= '0;
      err_q <= 1'b0;
      l1_q <= '0;
    end else begin
      word_q <= word_d;
      vld_q <= vld_d;
      wseq_q <= wseq_d;
      err_q <= err_d;
      l1_q <= l1_d;
    end
  end

  assign tx_word = word_q;
  assign tx_word_valid = vld_q;
  assign tx_word_seq = wseq_q;
  assign aux_tx_err = err_q;
  assign layer1_status_bit_port_los = l1_q[0];
  assign layer1_status_bit_port_lof = l1_q[1];
  assign layer1_status_bit_port_rai = l1_q[2];

  // ****************************************
  // Assertions
  // ****************************************
  default clocking cb @(posedge mclk); endclocking
  default disable iff (!rst_n);

  sequence run_steady;
    run && link_enable ##1 run && link_enable;
  endsequence

  // A running count must come back as a word exactly LAT+1 cycles later
  take_latency_a: assert property (run |-> ##LAT1
      (tx_word_valid && tx_word_seq == $past(aux_tx_seq, LAT1)))
    else $error("word taken at wrong latency");
  mask_priority_a: assert property (tx_word_valid |->
      ((tx_word ^ $past(aux_tx_data)) & $past(aux_tx_mask)) == 32'h0)
    else $error("masked bits not taken from aux data");
  kchar_err_a: assert property ($past(take.kchar && take.vld) &&
      $past(aux_tx_mask[31:24] != 8'h00) |-> aux_tx_err)
    else $error("fault flag missing after masked special character");
  no_err_a: assert property ($past(aux_tx_mask) == 32'h0 |-> !aux_tx_err)
    else $error("fault flag without mask");
  seq_wrap_a: assert property (run_steady ##0 seq_q == seq_last |=> seq_q == 6'h00)
    else $error("sequence count did not wrap");
  low_rate_a: assert property (run && line_rate == 3'h0 |->
      aux_tx_ctrl == ((seq_q == 6'h00) ? 4'h8 : 4'h0))
    else $error("lowest rate slot flags wrong");
  rate_6g_a: assert property (run && line_rate == 3'h5 && seq_q == 6'h02 |->
      aux_tx_ctrl == 4'hC)
    else $error("control word length wrong at 6.144");
  bf_pulse_a: assert property (aux_tx_bf_pulse |->
      seq_q == 6'h00 ##1 !aux_tx_bf_pulse)
    else $error("frame pulse off count zero");
  // Lane [7:0] holds the latest byte, so it alone decides if any payload lane exists
  direct_ready_a: assert property (direct_tx_ready ==
      (run && ({seq_q, 2'h3} >= {2'h0, cw_bytes})))
    else $error("direct port readiness wrong");
  // First edge after reset still shows the reset value, so skip it
  l1_bits_a: assert property ($past(rst_n) |->
      {layer1_status_bit_port_rai, layer1_status_bit_port_lof, layer1_status_bit_port_los} ==
      $past({layer1_status_bit_port_rai_in, layer1_status_bit_port_lof_in,
             layer1_status_bit_port_los_in}))
    else $error("status bit not carried");
endmodule

// [include/atx_cfg.svh]
`ifndef ATX_CFG_SVH
`define ATX_CFG_SVH

// ****************************************
// Widths and frame geometry
// ****************************************
`define ATX_DATA_W 32
`define ATX_LANES 4
`define ATX_SEQ_W 6
`define ATX_BF_W 8
`define ATX_HF_W 8
`define ATX_BF_LAST 8'hFF
`define ATX_HF_LAST 8'h95
`define ATX_EXTRA_LAT_DEF 0

// ****************************************
// Control word bytes per line rate
// ****************************************
`define ATX_CW_0G6 6'h01
`define ATX_CW_1G2 6'h02
`define ATX_CW_2G4 6'h04
`define ATX_CW_3G0 6'h05
`define ATX_CW_4G9 6'h08
`define ATX_CW_6G1 6'h0A
`define ATX_CW_9G8 6'h10

// ****************************************
// Special characters
// ****************************************
`define ATX_KCHAR 8'hBC
`endif

// [include/atx_pkg.sv]
package atx_pkg;
  typedef enum logic [2:0] {
    ATX_RATE_0G6 = 3'h0,
    ATX_RATE_1G2 = 3'h1,
    ATX_RATE_2G4 = 3'h2,
    ATX_RATE_3G0 = 3'h3,
    ATX_RATE_4G9 = 3'h4,
    ATX_RATE_6G1 = 3'h5,
    ATX_RATE_9G8 = 3'h6
  } atx_rate_t;

  typedef enum logic [1:0] {
    ATX_ST_IDLE = 2'h1,
    ATX_ST_RUN = 2'h2
  } atx_state_t;

  typedef struct packed {
    logic vld;
    logic [5:0] seq;
    logic [3:0] ctrl;
    logic kchar;
    logic dready;
  } atx_stage_t;
endpackage

// [tb/atx_user_model.sv]
`timescale 1ns/10ps
module atx_user_model #(
  parameter int LAT = 1
) (
  input wire logic mclk,
  input wire logic [5:0] aux_tx_seq,
  input wire logic [3:0] aux_tx_ctrl,
  input wire logic [1:0] mask_sel,
  input wire logic [1:0] skew,
  output logic [31:0] aux_tx_data,
  output logic [31:0] aux_tx_mask
);
  logic [5:0] sh [0:7];
  logic [3:0] ch [0:7];
  logic [3:0] nc;
  int k;
  initial begin
    aux_tx_data = 32'h0;
    aux_tx_mask = 32'h0;
    for (int i = 0; i < 8; i++) begin
      sh[i] = 6'h0;
      ch[i] = 4'h0;
    end
  end
  always @(posedge mclk) begin
    for (int i = 7; i > 0; i--) begin
      sh[i] <= sh[i-1];
      ch[i] <= ch[i-1];
    end
    sh[0] <= aux_tx_seq;
    ch[0] <= aux_tx_ctrl;
  end
  // Skew lets a test present words at the wrong latency on purpose
  always @(negedge mclk) begin
    k = LAT - 1 + int'(skew);
    nc = ~ch[k];
    aux_tx_data <= {2'h3, sh[k], 2'h2, sh[k], 2'h1, sh[k], 2'h0, sh[k]};
    case (mask_sel)
      2'h1: aux_tx_mask <= 32'hFFFFFFFF;
      2'h2: aux_tx_mask <= {{8{nc[3]}}, {8{nc[2]}}, {8{nc[1]}}, {8{nc[0]}}};
      default: aux_tx_mask <= 32'h0;
    endcase
  end
endmodule

// [tb/aux_tx_write_latency_framing_tb.sv]
`timescale 1ns/10ps
`include "atx_cfg.svh"
module aux_tx_write_latency_framing_tb;
  localparam int LAT = 3;
  localparam logic [31:0] SRC = 32'h5A6B7C8D;
  logic mclk, rst_n, link_enable, bf_p, hf_p, err, rdy, vld, en_q, rq;
  logic [2:0] line_rate, l1_in, l1_out;
  logic [5:0] seq, wseq;
  logic [3:0] ctl;
  logic [7:0] bf_n, hf_n;
  logic [1:0] mask_sel, skew;
  logic [31:0] dat, msk, dir_d, word;
  logic [5:0] sh [0:7];
  logic rh [0:7];
  int n_mismatch, checks, w, m, wc, rc;
  int tr [0:8] = '{0, 0, 5, 0, 1, 2, 3, 4, 6};
  int tm [0:8] = '{0, 1, 2, 1, 0, 2, 0, 1, 2};
  int ts [0:8] = '{0, 0, 0, 1, 0, 0, 0, 0, 0};

  atx_framer #(.EXTRA_LAT(LAT - 1)) atx_framer_inst (.mclk(mclk), .rst_n(rst_n),
    .link_enable(link_enable), .line_rate(line_rate), .aux_tx_seq(seq), .aux_tx_ctrl(ctl),
    .aux_tx_bf_pulse(bf_p), .aux_tx_hf_pulse(hf_p), .aux_tx_bf_num(bf_n), .aux_tx_hf_num(hf_n),
    .aux_tx_data(dat), .aux_tx_mask(msk), .aux_tx_err(err), .direct_tx_ready(rdy),
    .direct_tx_data(dir_d), .ctrl_word_src(SRC), .tx_word(word), .tx_word_valid(vld),
    .tx_word_seq(wseq), .layer1_status_bit_port_los_in(l1_in[0]),
    .layer1_status_bit_port_lof_in(l1_in[1]), .layer1_status_bit_port_rai_in(l1_in[2]),
    .layer1_status_bit_port_los(l1_out[0]), .layer1_status_bit_port_lof(l1_out[1]),
    .layer1_status_bit_port_rai(l1_out[2]));
  atx_user_model #(.LAT(LAT)) atx_user_model_inst (.mclk(mclk), .aux_tx_seq(seq),
    .aux_tx_ctrl(ctl), .mask_sel(mask_sel), .skew(skew), .aux_tx_data(dat), .aux_tx_mask(msk));

  initial begin
    mclk = 1'b0;
    forever #20 mclk = ~mclk;
  end

  task automatic chk(string what, logic [31:0] seen, logic [31:0] exp);
    checks++;
    if (seen !== exp) begin
      n_mismatch++;
      $display("unexpected %s: expected %h, seen %h", what, exp, seen);
    end
  endtask

  task tally_and_finish;
    $display("checks %0d, mismatches %0d", checks, n_mismatch);
    if (n_mismatch == 0 && checks > 0) $display("Result: passed");
    else $display("Result: failed");
    $finish;
  endtask

  function automatic int cw(logic [2:0] r);
    case (r)
      3'h1: return `ATX_CW_1G2;
      3'h2: return `ATX_CW_2G4;
      3'h3: return `ATX_CW_3G0;
      3'h4: return `ATX_CW_4G9;
      3'h5: return `ATX_CW_6G1;
      3'h6: return `ATX_CW_9G8;
      default: return `ATX_CW_0G6;
    endcase
  endfunction

  function automatic logic [3:0] cexp(logic [5:0] s);
    logic [3:0] c;
    for (int l = 0; l < 4; l++) c[l] = (4 * s + 3 - l) < w;
    return c;
  endfunction

  function automatic logic [31:0] exp_word(logic [5:0] s, int pi, logic [31:0] mk);
    logic [31:0] pat, base;
    logic [3:0] c;
    pat = {2'h3, 6'(pi), 2'h2, 6'(pi), 2'h1, 6'(pi), 2'h0, 6'(pi)};
    c = cexp(s);
    for (int l = 0; l < 4; l++) base[8*l+:8] = c[l] ? SRC[8*l+:8] : dir_d[8*l+:8];
    if (wc < m && s == 6'h0) base[31:24] = `ATX_KCHAR;
    return (mk & pat) | (~mk & base);
  endfunction

  // ****************************************
  // Monitor, also steering direct and status inputs
  // ****************************************
  // Bench inputs are sampled at the rising edge so the monitor never races the driver
  always @(posedge mclk) begin
    en_q <= link_enable;
    rq <= rst_n;
  end
  always @(negedge mclk) begin : mon
    logic run;
    logic [31:0] mk;
    logic [3:0] nc;
    int pi;
    run = en_q && rq;
    for (int i = 7; i > 0; i--) begin
      sh[i] = sh[i-1];
      rh[i] = rh[i-1];
    end
    sh[0] = seq;
    rh[0] = run;
    if (rq) begin
      chk("ctrl", ctl, run ? cexp(seq) : 4'h0);
      chk("ready", rdy, run && cexp(seq) != 4'hF);
      chk("frame pulse", bf_p, run && seq == 6'h0);
      chk("hyperframe pulse", hf_p, run && seq == 6'h0 && rc < m);
      if (run) chk("count", seq, rh[1] ? (sh[1] + 1) % m : 0);
      if (run) chk("frame number", bf_n, rc / m);
      chk("hyperframe number", hf_n, 32'h0);
      chk("word valid", vld, rh[LAT+1]);
      chk("status bits", l1_out, l1_in);
      if (rh[LAT+1]) begin
        pi = (wc < skew) ? 0 : (sh[LAT+1] + m - skew) % m;
        nc = ~cexp(sh[LAT+1]);
        mk = mask_sel == 2'h1 ? 32'hFFFFFFFF : mask_sel == 2'h0 ? 32'h0 :
          {{8{nc[3]}}, {8{nc[2]}}, {8{nc[1]}}, {8{nc[0]}}};
        chk("word count", wseq, sh[LAT+1]);
        chk("word", word, exp_word(sh[LAT+1], pi, mk));
        chk("insert fault", err, sh[LAT+1] == 6'h0 && wc < m && |mk[31:24]);
        wc++;
      end else wc = 0;
      rc = run ? rc + 1 : 0;
    end
    dir_d = dir_d + 32'h01010101;
    l1_in = l1_in + 3'h1;
  end

  initial begin
    rst_n = 1'b0;
    link_enable = 1'b0;
    line_rate = 3'h0;
    mask_sel = 2'h0;
    skew = 2'h0;
    dir_d = 32'h03020100;
    l1_in = 3'h0;
    n_mismatch = 0;
    checks = 0;
    wc = 0;
    rc = 0;
    w = 1;
    m = 4;
    for (int i = 0; i < 8; i++) begin
      sh[i] = 6'h0;
      rh[i] = 1'b0;
    end
    repeat (20) @(negedge mclk);
    rst_n = 1'b1;
    repeat (4) @(negedge mclk);
    for (int t = 0; t < 9; t++) begin
      line_rate = 3'(tr[t]);
      mask_sel = 2'(tm[t]);
      skew = 2'(ts[t]);
      w = cw(line_rate);
      m = 4 * w;
      link_enable = 1'b1;
      for (int k = 0; vld !== 1'b1; k++) begin
        if (k == 20) begin
          n_mismatch++;
          tally_and_finish();
        end
        @(negedge mclk);
      end
      repeat (2 * m) @(negedge mclk);
      link_enable = 1'b0;
      repeat (LAT + 8) @(negedge mclk);
      $display("test %0d done: rate %0d mask %0d skew %0d", t, tr[t], tm[t], ts[t]);
    end
    tally_and_finish();
  end
endmodule
